//--- rtl/rmfc_top.sv
// buck control register and boost fault sequencing
`timescale 1ns/1ps
`default_nettype none
module rmfc_top #(
	parameter int SOFT_START_CYCLES = rmfc_pkg::SOFT_START_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic disch_wr,
	input wire logic disch_wdata,
	output logic boost_discharge_disable,
	// wake pin, asynchronous
	input wire logic standby_exit_pin,
	// buck decoded outputs
	output logic buck_off,
	output logic buck_pfm,
	output logic buck_skip,
	output logic buck_pwm,
	output logic buck_sel_1v25,
	output logic buck_sel_1v0_link,
	// boost control and analog comparators, asynchronous
	input wire logic boost_enable,
	input wire logic cmp_under_voltage,
	input wire logic cmp_uv_recovered,
	input wire logic cmp_over_current,
	input wire logic cmp_short,
	input wire logic cmp_over_voltage,
	// boost outputs
	output logic boost_run,
	output logic boost_switch_off,
	output logic boost_current_limit,
	output logic uv_cmp_enable,
	output logic isolation_gate_drive,
	output logic discharge_enable,
	output logic boost_fault_flag,
	output logic regulator_fault_irq
);
	// refuse settings that the counter and the field map cannot serve
	if (SOFT_START_CYCLES < 1 || SOFT_START_CYCLES > 65535) begin : g_bad_soft_start
		$error("soft start count out of range");
	end
	if (rmfc_pkg::SOFT_START_CYC > 65535) begin : g_bad_soft_default
		$error("default soft start count too wide for the timer");
	end
	if (rmfc_pkg::STATE_LSB + 3 > rmfc_pkg::WAKE_LSB) begin : g_bad_state_field
		$error("state field overlaps wake field");
	end
	if (rmfc_pkg::WAKE_LSB + 3 > rmfc_pkg::VSEL_LSB) begin : g_bad_wake_field
		$error("wake field overlaps voltage select");
	end
	if (rmfc_pkg::VSEL_LSB + 2 > 8) begin : g_bad_vsel_field
		$error("voltage select outside the register");
	end

	logic [7:0] buck_rail_control_r;
	logic [6:0] s_q;
	logic wake_s, en_s, uv_s, uvok_s, oc_s, sc_s, ov_s;
	logic wake_d_r;
	logic en_d_r;
	logic startup_r;
	logic uv_r;
	logic latched_r;
	logic softstart_r;
	logic [15:0] ss_cnt_r;
	logic disch_r;
	logic [2:0] wake_code;
	logic [2:0] st;
	logic [1:0] vsel;
	logic rail_on;

	// single-cycle events and fault terms
	logic wr_hit;
	logic rd_hit;
	logic wake_rise;
	logic en_rise;
	logic ss_active;
	logic startup_done;
	logic oc_fault;
	logic fault_any;

	// next values of the registered buck decode
	logic buck_off_nxt;
	logic buck_pfm_nxt;
	logic buck_skip_nxt;
	logic buck_pwm_nxt;
	logic sel_1v25_nxt;
	logic sel_1v0_nxt;

	// next values of the registered boost outputs
	logic boost_run_nxt;
	logic switch_off_nxt;
	logic current_limit_nxt;
	logic uv_cmp_enable_nxt;
	logic gate_drive_nxt;
	logic discharge_enable_nxt;
	logic fault_flag_nxt;

	// every pin and comparator goes through two flops
	rmfc_sync #(.W(7)) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.d({standby_exit_pin, boost_enable, cmp_under_voltage, cmp_uv_recovered,
			cmp_over_current, cmp_short, cmp_over_voltage}),
		.q(s_q)
	);
	assign {wake_s, en_s, uv_s, uvok_s, oc_s, sc_s, ov_s} = s_q;

	assign wake_code = buck_rail_control_r[rmfc_pkg::WAKE_LSB +: 3];
	assign st = buck_rail_control_r[rmfc_pkg::STATE_LSB +: 3];
	assign vsel = buck_rail_control_r[rmfc_pkg::VSEL_LSB +: 2];

	// strobes derived from the bus and from the synchronised pins
	assign wr_hit = reg_wr && (reg_addr == rmfc_pkg::BUCK_CTRL_ADDR);
	assign rd_hit = reg_addr == rmfc_pkg::BUCK_CTRL_ADDR;
	assign wake_rise = wake_s && !wake_d_r;
	assign en_rise = en_s && !en_d_r;

	// buck register; wake copy on pin rising edge wins over a write
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			buck_rail_control_r <= rmfc_pkg::BUCK_CTRL_RESET;
			wake_d_r <= 1'b0;
		end else begin
			wake_d_r <= wake_s;
			if (wr_hit) begin
				buck_rail_control_r <= reg_wdata;
			end
			if (wake_rise && wake_code[2]) begin // codes 0..3 do not copy
				buck_rail_control_r[rmfc_pkg::STATE_LSB +: 3] <= wake_code;
			end
		end
	end

	// read mux, unmapped addresses read zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rd_hit ? buck_rail_control_r : 8'h00;
		end
	end

	// state decode; reserved codes fall back to off
	always_comb begin
		buck_off_nxt = 1'b0;
		buck_pfm_nxt = 1'b0;
		buck_skip_nxt = 1'b0;
		buck_pwm_nxt = 1'b0;
		unique case (st)
			rmfc_pkg::ST_OFF: buck_off_nxt = 1'b1;
			rmfc_pkg::ST_PFM: buck_pfm_nxt = 1'b1;
			rmfc_pkg::ST_SKIP: buck_skip_nxt = 1'b1;
			rmfc_pkg::ST_PWM: buck_pwm_nxt = 1'b1;
			default: buck_off_nxt = 1'b1; // reserved code keeps the rail safe
		endcase
	end

	// voltage select decode; codes 2 and 3 drive neither level
	always_comb begin
		sel_1v25_nxt = 1'b0;
		sel_1v0_nxt = 1'b0;
		unique case (vsel)
			rmfc_pkg::VSEL_1V25: sel_1v25_nxt = 1'b1;
			rmfc_pkg::VSEL_1V0: sel_1v0_nxt = 1'b1;
			default: sel_1v25_nxt = 1'b0; // reserved, no level selected
		endcase
	end

	// registered decode; reset leaves the buck off
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			buck_off <= 1'b1;
			buck_pfm <= 1'b0;
			buck_skip <= 1'b0;
			buck_pwm <= 1'b0;
			buck_sel_1v25 <= 1'b0;
			buck_sel_1v0_link <= 1'b0;
		end else begin
			buck_off <= buck_off_nxt;
			buck_pfm <= buck_pfm_nxt;
			buck_skip <= buck_skip_nxt;
			buck_pwm <= buck_pwm_nxt;
			buck_sel_1v25 <= sel_1v25_nxt;
			buck_sel_1v0_link <= sel_1v0_nxt;
		end
	end

	// discharge-disable bit, separate control register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			disch_r <= rmfc_pkg::DISCH_RESET;
		end else if (disch_wr) begin
			disch_r <= disch_wdata;
		end
	end
	assign boost_discharge_disable = disch_r;

	// soft start timer, short detector masked while it runs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			en_d_r <= 1'b0;
			softstart_r <= 1'b0;
			ss_cnt_r <= 16'h0000;
		end else begin
			en_d_r <= en_s;
			if (!en_s) begin
				softstart_r <= 1'b0;
				ss_cnt_r <= 16'h0000;
			end else if (!en_d_r) begin
				softstart_r <= 1'b1;
				ss_cnt_r <= 16'(SOFT_START_CYCLES - 1);
			end else if (softstart_r) begin
				if (ss_cnt_r == 16'h0000) begin
					softstart_r <= 1'b0;
				end else begin
					ss_cnt_r <= ss_cnt_r - 16'h0001;
				end
			end
		end
	end

	// latched short or over-voltage, cleared only by disabling the rail
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			latched_r <= 1'b0;
		end else if (!en_s) begin
			latched_r <= 1'b0;
		end else if ((sc_s && !ss_active) || ov_s) begin
			latched_r <= 1'b1;
		end
	end

	// start-up: flag held until output is steady
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			startup_r <= 1'b0;
		end else if (en_rise) begin
			startup_r <= 1'b1;
		end else if (!en_s || startup_done) begin
			startup_r <= 1'b0;
		end
	end

	// under-voltage with hysteresis after start-up
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			uv_r <= 1'b0;
		end else if (!en_s || startup_r) begin
			uv_r <= 1'b0;
		end else if (uv_s) begin
			uv_r <= 1'b1;
		end else if (uvok_s) begin
			uv_r <= 1'b0; // flag itself still or-ed with others
		end
	end

	// the timer only loads on the first enabled cycle, so mask that one too
	assign ss_active = softstart_r || !en_d_r;
	assign startup_done = uvok_s && !ss_active; // ramp over, output steady

	// fault terms: any single source holds the flag
	assign rail_on = en_s && !latched_r;
	assign oc_fault = oc_s && rail_on;
	assign fault_any = startup_r || uv_r || oc_fault || latched_r;
	assign fault_flag_nxt = en_s && fault_any;

	// next values of the boost outputs
	assign boost_run_nxt = rail_on;
	assign switch_off_nxt = !rail_on || oc_s;
	assign current_limit_nxt = oc_fault;
	assign uv_cmp_enable_nxt = en_s;
	// gate drive held only while enabled and no short or over-voltage shutdown latched
	assign gate_drive_nxt = rail_on;
	// discharge only with the rail off and the host not inhibiting it
	assign discharge_enable_nxt = !en_s && !disch_r;

	// outputs from flops: one cycle later, but no glitches on the pins
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			boost_run <= 1'b0;
			boost_switch_off <= 1'b1;
			boost_current_limit <= 1'b0;
			uv_cmp_enable <= 1'b0;
			isolation_gate_drive <= 1'b0;
			discharge_enable <= 1'b0;
			boost_fault_flag <= 1'b0;
			regulator_fault_irq <= 1'b0;
		end else begin
			boost_run <= boost_run_nxt;
			boost_switch_off <= switch_off_nxt;
			boost_current_limit <= current_limit_nxt;
			uv_cmp_enable <= uv_cmp_enable_nxt;
			isolation_gate_drive <= gate_drive_nxt;
			discharge_enable <= discharge_enable_nxt;
			boost_fault_flag <= fault_flag_nxt;
			regulator_fault_irq <= fault_flag_nxt;
		end
	end
endmodule : rmfc_top
`default_nettype wire

//--- rtl/rmfc_pkg.sv
// constants shared by the regulator mode and fault control block
package rmfc_pkg;
	localparam logic [7:0] BUCK_CTRL_ADDR = 8'h3C;
	localparam logic [7:0] BUCK_CTRL_RESET = 8'h24;
	localparam int STATE_LSB = 0;
	localparam int WAKE_LSB = 3;
	localparam int VSEL_LSB = 6;
	localparam logic [2:0] ST_OFF = 3'h4;
	localparam logic [2:0] ST_PFM = 3'h5;
	localparam logic [2:0] ST_SKIP = 3'h6;
	localparam logic [2:0] ST_PWM = 3'h7;
	localparam logic [1:0] VSEL_1V25 = 2'h0;
	localparam logic [1:0] VSEL_1V0 = 2'h1;
	localparam logic DISCH_RESET = 1'h1;
	localparam int CLK_HZ = 10000000;
	localparam int SOFT_START_US = 4000;
	localparam int SOFT_START_CYC = SOFT_START_US * (CLK_HZ / 1000000);
endpackage : rmfc_pkg

//--- rtl/rmfc_sync.sv
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module rmfc_sync #(
	parameter int W = 1
) (
	// clock
	input wire logic clk_sys,
	input wire logic rst,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : rmfc_sync
`default_nettype wire

//--- sim/rmfc_props.sv
// port assertions for the regulator control block
`timescale 1ns/1ps
`default_nettype none
module rmfc_props #(
	parameter int SOFT_START_CYCLES = 20
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// watched ports
	input wire logic boost_enable, cmp_under_voltage, cmp_over_current, cmp_short,
	input wire logic buck_off, buck_pfm, buck_skip, buck_pwm, buck_sel_1v25, buck_sel_1v0_link,
	input wire logic boost_run, boost_switch_off, isolation_gate_drive, discharge_enable,
	input wire logic boost_discharge_disable, boost_fault_flag, regulator_fault_irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// run length, so a short cannot cut soft start early
	logic [15:0] run_cnt_r;
	always_ff @(posedge clk_sys) begin
		if (rst || !boost_run) run_cnt_r <= 16'h0000;
		else run_cnt_r <= run_cnt_r + 16'h0001;
	end
	mode_onehot_a: assert property ($onehot({buck_off, buck_pfm, buck_skip, buck_pwm})) else $error("mode");
	vsel_excl_a: assert property (!(buck_sel_1v25 && buck_sel_1v0_link)) else $error("vsel");
	start_flag_a: assert property ($rose(boost_enable) |-> ##[1:4] boost_fault_flag) else $error("start");
	uv_flag_a: assert property ($rose(cmp_under_voltage) && boost_run |-> ##[1:4] boost_fault_flag)
		else $error("uv");
	oc_off_a: assert property ($rose(cmp_over_current) && boost_enable |-> ##[1:4] (boost_fault_flag && boost_switch_off))
		else $error("oc");
	short_cut_a: assert property ($rose(cmp_short) && run_cnt_r > SOFT_START_CYCLES |-> ##[1:4] !(isolation_gate_drive || boost_run))
		else $error("short");
	latch_hold_a: assert property (boost_enable && $past(boost_enable) && boost_fault_flag && !isolation_gate_drive
		|=> boost_fault_flag) else $error("latch");
	blank_ss_a: assert property ($fell(boost_run) && cmp_short && boost_enable |-> run_cnt_r >= SOFT_START_CYCLES - 3)
		else $error("blank");
	gate_run_a: assert property (boost_run |-> isolation_gate_drive) else $error("gate");
	disch_bit_a: assert property (discharge_enable |-> !$past(boost_discharge_disable)) else $error("disch");
	irq_flag_a: assert property (regulator_fault_irq == boost_fault_flag) else $error("irq");
endmodule : rmfc_props
bind rmfc_top rmfc_props #(.SOFT_START_CYCLES(SOFT_START_CYCLES)) u_props (.*);
`default_nettype wire

//--- sim/rmfc_host.sv
// host bus controller model on the register port, parallel address and data
`timescale 1ns/1ps
`default_nettype none
module rmfc_host (
	// clock and read data
	input wire logic clk_sys,
	input wire logic [7:0] reg_rdata,
	// register and discharge writes
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic disch_wr,
	output logic disch_wdata
);
	// idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		disch_wr = 1'b0;
		disch_wdata = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_wdata = ~d; // released data no longer holds the value
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask : rd
	// power-up setup: wake field, then discharge bit
	task automatic init(input logic [2:0] ex, input logic dis);
		wr(rmfc_pkg::BUCK_CTRL_ADDR, {2'h0, ex, rmfc_pkg::ST_OFF});
		@(negedge clk_sys);
		disch_wdata = dis;
		disch_wr = 1'b1;
		@(negedge clk_sys);
		disch_wr = 1'b0;
		// registered discharge output follows one cycle later
		@(negedge clk_sys);
	endtask : init
endmodule : rmfc_host
`default_nettype wire

//--- sim/testbench.sv
// register and boost fault sequence bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys, rst = 1'b1, standby_exit_pin = 1'b0, boost_enable = 1'b0, cmp_under_voltage = 1'b0;
	logic cmp_uv_recovered = 1'b0, cmp_over_current = 1'b0, cmp_short = 1'b0, cmp_over_voltage = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
	logic reg_wr, disch_wr, disch_wdata, boost_discharge_disable, buck_off, buck_pfm, buck_skip, buck_pwm;
	logic buck_sel_1v25, buck_sel_1v0_link, boost_run, boost_switch_off, boost_current_limit;
	logic uv_cmp_enable, isolation_gate_drive, discharge_enable, boost_fault_flag, regulator_fault_irq;
	int error_cnt = 0;
	int n_compared = 0;
	// short soft start keeps the run brief
	rmfc_top #(.SOFT_START_CYCLES(20)) dut (.*);
	rmfc_host host (.*);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic step(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : step
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk8
	task automatic chk1(input string nm, input logic e, input logic g);
		chk8(nm, {7'h00, e}, {7'h00, g});
	endtask : chk1
	task automatic tally_and_finish;
		if (error_cnt == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	// main sequence
	initial begin
		step(10);
		rst = 1'b0;
		host.rd(rmfc_pkg::BUCK_CTRL_ADDR, rd_v);
		chk8("reset", rmfc_pkg::BUCK_CTRL_RESET, rd_v);
		chk1("disch", rmfc_pkg::DISCH_RESET, boost_discharge_disable);
		for (int i = 0; i < 8; i++) begin
			host.wr(rmfc_pkg::BUCK_CTRL_ADDR, {i[1:0], 3'h0, i[2:0]});
			host.rd(rmfc_pkg::BUCK_CTRL_ADDR, rd_v);
			chk8("readback", {i[1:0], 3'h0, i[2:0]}, rd_v);
			chk8("mode", (i < 4) ? 8'h08 : 8'h01 << (7 - i), {4'h0, buck_off, buck_pfm, buck_skip, buck_pwm});
			chk8("vsel", {6'h00, i[1:0] == 2'h0, i[1:0] == 2'h1}, {6'h00, buck_sel_1v25, buck_sel_1v0_link});
		end
		host.wr(8'h3D, 8'hFF);
		host.rd(8'h3D, rd_v);
		chk8("unmapped", 8'h00, rd_v);
		host.init(rmfc_pkg::ST_PWM, 1'b0);
		chk1("discharge", 1'b1, discharge_enable);
		standby_exit_pin = 1'b1;
		step(5);
		chk1("wake copy", 1'b1, buck_pwm);
		standby_exit_pin = 1'b0;
		host.wr(rmfc_pkg::BUCK_CTRL_ADDR, 8'h1F);
		standby_exit_pin = 1'b1;
		step(5);
		chk1("no copy", 1'b1, buck_pwm);
		boost_enable = 1'b1;
		step(5);
		chk8("startup", 8'h03, {6'h00, boost_fault_flag, uv_cmp_enable});
		cmp_uv_recovered = 1'b1;
		step(25);
		chk8("ready", 8'h01, {6'h00, boost_fault_flag, isolation_gate_drive});
		cmp_under_voltage = 1'b1;
		cmp_uv_recovered = 1'b0;
		step(4);
		chk1("uv", 1'b1, boost_fault_flag);
		cmp_over_current = 1'b1;
		cmp_under_voltage = 1'b0;
		cmp_uv_recovered = 1'b1;
		step(4);
		chk8("oc", 8'h07, {5'h00, boost_fault_flag, boost_switch_off, boost_current_limit});
		cmp_over_current = 1'b0;
		step(4);
		chk8("oc gone", 8'h00, {6'h00, boost_fault_flag, boost_switch_off});
		cmp_short = 1'b1;
		step(4);
		cmp_short = 1'b0;
		step(4);
		chk8("short", 8'h01, {5'h00, boost_run, isolation_gate_drive, boost_fault_flag});
		boost_enable = 1'b0;
		step(4);
		chk1("cleared", 1'b0, boost_fault_flag);
		cmp_short = 1'b1;
		boost_enable = 1'b1;
		step(12);
		chk1("blanked", 1'b1, boost_run);
		step(14);
		chk1("short late", 1'b0, boost_run);
		boost_enable = 1'b0;
		cmp_short = 1'b0;
		step(4);
		boost_enable = 1'b1;
		step(26);
		cmp_over_voltage = 1'b1;
		step(4);
		cmp_over_voltage = 1'b0;
		step(4);
		chk8("ov", 8'h01, {6'h00, boost_run, boost_fault_flag});
		boost_enable = 1'b0;
		host.init(3'h3, 1'b1);
		chk1("inhibit", 1'b0, discharge_enable);
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
